/* src/power_mgmt_status_control.sv */
// Purpose: low-voltage detect/warning and power-down control registers
// Assumes: stop sequencer and reset controller share clk
// Notes: por_rst clears everything, sys_rst keeps the trip selects and the wake flags
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_status_control (
  // clock, resets, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic por_rst,
  input wire logic ce,
  // register port
  input wire logic [pmsc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pmsc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pmsc_pkg::DATA_W-1:0] reg_rdata,
  // analog comparators, asynchronous
  input wire logic undervolt_det_raw,
  input wire logic supply_warn_raw,
  // stop sequencer
  input wire logic stop_active,
  input wire logic full_pd_wake,
  input wire logic partial_pd_wake,
  // requests and controls
  output logic undervolt_irq,
  output logic undervolt_rst,
  output logic undervolt_det_run,
  output logic ref_buffer_en,
  output logic undervolt_trip_sel,
  output logic supply_warn_trip_sel,
  output logic powerdown_allow,
  output logic powerdown_kind_sel,
  output logic io_hold
);
  logic any_rst;
  logic det_sync;
  logic warn_sync;
  logic wr_detect;
  logic wr_pdown;
  logic wr_warn;
  logic undervolt_ack;
  logic supply_warn_ack;
  logic partial_powerdown_ack;
  logic det_active;
  // control bits
  logic irq_en_reg, irq_en_next;
  logic rst_en_reg, rst_en_next;
  logic stop_en_reg, stop_en_next;
  logic logic_en_reg, logic_en_next;
  logic ref_buf_reg, ref_buf_next;
  logic allow_reg, allow_next;
  logic kind_reg, kind_next;
  logic pd_locked_reg, pd_locked_next;
  logic uv_trip_reg, uv_trip_next;
  logic warn_trip_reg, warn_trip_next;
  // flags
  logic uv_flag_reg, uv_flag_next;
  logic warn_flag_reg, warn_flag_next;
  logic full_pd_reg, full_pd_next;
  logic part_pd_reg, part_pd_next;
  // registered outputs
  logic irq_reg, irq_next;
  logic rst_req_reg, rst_req_next;
  logic det_run_reg, det_run_next;
  logic [pmsc_pkg::DATA_W-1:0] rdata_reg, rdata_next;

  assign any_rst = sys_rst | por_rst;

  // comparators are asynchronous to clk
  level_sync #(
    .WIDTH(2)
  ) u_cmp_sync (
    .clk(clk),
    .rst(any_rst),
    .ce(ce),
    .d({undervolt_det_raw, supply_warn_raw}),
    .q({det_sync, warn_sync})
  );

  // decode; acks are one-cycle pulses, writing 0 does nothing
  always_comb begin
    wr_detect = reg_wr && (reg_addr == pmsc_pkg::OFF_DETECT);
    wr_pdown = reg_wr && (reg_addr == pmsc_pkg::OFF_PDOWN);
    wr_warn = reg_wr && (reg_addr == pmsc_pkg::OFF_WARN);
    undervolt_ack = wr_detect && reg_wdata[pmsc_pkg::B_UV_ACK];
    partial_powerdown_ack = wr_pdown && reg_wdata[pmsc_pkg::B_PART_PD_ACK];
    supply_warn_ack = wr_warn && reg_wdata[pmsc_pkg::B_WARN_ACK];
    // detector runs only when enabled, and in stop only if allowed
    det_active = logic_en_reg && (!stop_active || stop_en_reg);
  end

  // control registers
  always_comb begin
    irq_en_next = irq_en_reg;
    rst_en_next = rst_en_reg;
    stop_en_next = stop_en_reg;
    logic_en_next = logic_en_reg;
    ref_buf_next = ref_buf_reg;
    allow_next = allow_reg;
    kind_next = kind_reg;
    pd_locked_next = pd_locked_reg;
    uv_trip_next = uv_trip_reg;
    warn_trip_next = warn_trip_reg;
    if (wr_detect) begin
      // reserved bit is not stored, so a stray 1 is harmless
      irq_en_next = reg_wdata[pmsc_pkg::B_UV_IRQ_EN];
      rst_en_next = reg_wdata[pmsc_pkg::B_UV_RST_EN];
      stop_en_next = reg_wdata[pmsc_pkg::B_UV_STOP_EN];
      logic_en_next = reg_wdata[pmsc_pkg::B_UV_LOGIC_EN];
      ref_buf_next = reg_wdata[pmsc_pkg::B_REF_BUF];
    end
    // both write-once bits lock on the first write to this register
    if (wr_pdown && !pd_locked_reg) begin
      allow_next = reg_wdata[pmsc_pkg::B_PD_ALLOW];
      kind_next = reg_wdata[pmsc_pkg::B_PD_KIND];
      pd_locked_next = pmsc_pkg::BIT_SET;
    end
    if (wr_warn) begin
      uv_trip_next = reg_wdata[pmsc_pkg::B_UV_TRIP];
      warn_trip_next = reg_wdata[pmsc_pkg::B_WARN_TRIP];
    end
  end

  always_ff @(posedge clk) begin
    if (any_rst) begin
      irq_en_reg <= pmsc_pkg::BIT_CLR;
      rst_en_reg <= pmsc_pkg::BIT_CLR;
      stop_en_reg <= pmsc_pkg::BIT_CLR;
      logic_en_reg <= pmsc_pkg::BIT_CLR;
      ref_buf_reg <= pmsc_pkg::BIT_CLR;
      allow_reg <= pmsc_pkg::BIT_CLR;
      kind_reg <= pmsc_pkg::BIT_CLR;
      pd_locked_reg <= pmsc_pkg::BIT_CLR;
      // trip selects survive all but power-on reset
      if (por_rst) begin
        uv_trip_reg <= pmsc_pkg::BIT_CLR;
        warn_trip_reg <= pmsc_pkg::BIT_CLR;
      end
    end else if (ce) begin
      irq_en_reg <= irq_en_next;
      rst_en_reg <= rst_en_next;
      stop_en_reg <= stop_en_next;
      logic_en_reg <= logic_en_next;
      ref_buf_reg <= ref_buf_next;
      allow_reg <= allow_next;
      kind_reg <= kind_next;
      pd_locked_reg <= pd_locked_next;
      uv_trip_reg <= uv_trip_next;
      warn_trip_reg <= warn_trip_next;
    end
  end

  // sticky flags: a set in the clearing cycle wins
  always_comb begin
    uv_flag_next = (uv_flag_reg && !undervolt_ack) || (det_active && det_sync);
    // ack only clears once the supply is back above the trip
    warn_flag_next = (warn_flag_reg && !(supply_warn_ack && !warn_sync)) || warn_sync;
    full_pd_next = full_pd_reg || full_pd_wake;
    part_pd_next = (part_pd_reg && !partial_powerdown_ack) || partial_pd_wake;
  end

  always_ff @(posedge clk) begin
    if (any_rst) begin
      uv_flag_reg <= pmsc_pkg::BIT_CLR;
      warn_flag_reg <= pmsc_pkg::BIT_CLR;
      // wake flags must survive the reset that ends a stop
      if (por_rst) begin
        full_pd_reg <= pmsc_pkg::BIT_CLR;
        part_pd_reg <= pmsc_pkg::BIT_CLR;
      end
    end else if (ce) begin
      uv_flag_reg <= uv_flag_next;
      warn_flag_reg <= warn_flag_next;
      full_pd_reg <= full_pd_next;
      part_pd_reg <= part_pd_next;
    end
  end

  // requests and read data
  always_comb begin
    irq_next = logic_en_reg && irq_en_reg && uv_flag_reg;
    rst_req_next = logic_en_reg && rst_en_reg && uv_flag_reg;
    det_run_next = det_active;
    rdata_next = pmsc_pkg::BYTE_CLR;
    if (reg_rd) begin
      unique case (reg_addr)
        pmsc_pkg::OFF_DETECT: begin
          rdata_next[pmsc_pkg::B_UV_FLAG] = uv_flag_reg;
          rdata_next[pmsc_pkg::B_UV_IRQ_EN] = irq_en_reg;
          rdata_next[pmsc_pkg::B_UV_RST_EN] = rst_en_reg;
          rdata_next[pmsc_pkg::B_UV_STOP_EN] = stop_en_reg;
          rdata_next[pmsc_pkg::B_UV_LOGIC_EN] = logic_en_reg;
          rdata_next[pmsc_pkg::B_REF_BUF] = ref_buf_reg;
        end
        pmsc_pkg::OFF_PDOWN: begin
          rdata_next[pmsc_pkg::B_FULL_PD_FLAG] = full_pd_reg;
          rdata_next[pmsc_pkg::B_PART_PD_FLAG] = part_pd_reg;
          rdata_next[pmsc_pkg::B_PD_ALLOW] = allow_reg;
          rdata_next[pmsc_pkg::B_PD_KIND] = kind_reg;
        end
        pmsc_pkg::OFF_WARN: begin
          rdata_next[pmsc_pkg::B_WARN_FLAG] = warn_flag_reg;
          rdata_next[pmsc_pkg::B_UV_TRIP] = uv_trip_reg;
          rdata_next[pmsc_pkg::B_WARN_TRIP] = warn_trip_reg;
        end
        default: rdata_next = pmsc_pkg::BYTE_CLR;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (any_rst) begin
      irq_reg <= pmsc_pkg::BIT_CLR;
      rst_req_reg <= pmsc_pkg::BIT_CLR;
      det_run_reg <= pmsc_pkg::BIT_CLR;
      rdata_reg <= pmsc_pkg::BYTE_CLR;
    end else if (ce) begin
      irq_reg <= irq_next;
      rst_req_reg <= rst_req_next;
      det_run_reg <= det_run_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign undervolt_irq = irq_reg;
  assign undervolt_rst = rst_req_reg;
  assign undervolt_det_run = det_run_reg;
  assign ref_buffer_en = ref_buf_reg;
  assign undervolt_trip_sel = uv_trip_reg;
  assign supply_warn_trip_sel = warn_trip_reg;
  assign powerdown_allow = allow_reg;
  assign powerdown_kind_sel = kind_reg;
  // pins stay latched until software acks the partial flag
  assign io_hold = part_pd_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (any_rst);

  uv_flag_set_a: assert property (ce && det_active && det_sync |=> uv_flag_reg)
    else $error("undervolt flag missed a detect");
  uv_ack_clear_a: assert property (ce && undervolt_ack && !(det_active && det_sync)
    |=> !uv_flag_reg)
    else $error("undervolt ack did not clear flag");
  ack_reads_zero_a: assert property (ce && reg_rd |=> !reg_rdata[pmsc_pkg::B_UV_ACK]
    && !reg_rdata[pmsc_pkg::B_WARN_ACK])
    else $error("ack bit read back nonzero");
  irq_follow_a: assert property (ce ##1 ce |-> undervolt_irq
    == $past(irq_en_reg && logic_en_reg && uv_flag_reg))
    else $error("interrupt request wrong");
  rst_follow_a: assert property (ce && uv_flag_reg && logic_en_reg && rst_en_reg
    |=> undervolt_rst)
    else $error("reset request missing");
  stop_gate_a: assert property (stop_active && !stop_en_reg |-> !det_active)
    else $error("detector active in stop");
  logic_off_a: assert property (ce && !logic_en_reg |=> !undervolt_det_run && !undervolt_rst)
    else $error("detector effect while disabled");
  pd_once_a: assert property (ce && pd_locked_reg && wr_pdown
    |=> $stable(allow_reg) && $stable(kind_reg))
    else $error("write-once bit changed");
  warn_hold_a: assert property (ce && warn_flag_reg && warn_sync |=> warn_flag_reg)
    else $error("warning flag cleared while present");
  full_pd_a: assert property (ce && full_pd_wake |=> full_pd_reg [*2])
    else $error("full power-down flag not held");
  part_ack_a: assert property (ce && partial_powerdown_ack && !partial_pd_wake
    |=> !part_pd_reg && !io_hold)
    else $error("partial ack did not clear flag");

  irq_seen_c: cover property (ce && uv_flag_reg ##1 undervolt_irq);
  warn_cleared_c: cover property (warn_flag_reg && ce && supply_warn_ack && !warn_sync
    ##1 !warn_flag_reg);
  part_release_c: cover property (part_pd_reg ##1 !part_pd_reg);
  once_blocked_c: cover property (ce && pd_locked_reg && wr_pdown);
endmodule : power_mgmt_status_control
`default_nettype wire

/* src/pmsc_pkg.sv */
// Purpose: shared constants for the power management status/control block
// Assumes: 8-bit registers on a plain strobe port
// Notes: offsets are register indices on the local port
package pmsc_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 2;
  // register offsets
  localparam logic [ADDR_W-1:0] OFF_DETECT = 2'h0;
  localparam logic [ADDR_W-1:0] OFF_PDOWN = 2'h1;
  localparam logic [ADDR_W-1:0] OFF_WARN = 2'h2;
  // low_volt_detect_ctrl fields
  localparam int B_UV_FLAG = 7;
  localparam int B_UV_ACK = 6;
  localparam int B_UV_IRQ_EN = 5;
  localparam int B_UV_RST_EN = 4;
  localparam int B_UV_STOP_EN = 3;
  localparam int B_UV_LOGIC_EN = 2;
  localparam int B_UV_RSVD = 1;
  localparam int B_REF_BUF = 0;
  // power_down_ctrl fields
  localparam int B_FULL_PD_FLAG = 4;
  localparam int B_PART_PD_FLAG = 3;
  localparam int B_PART_PD_ACK = 2;
  localparam int B_PD_ALLOW = 1;
  localparam int B_PD_KIND = 0;
  // low_volt_warning_ctrl fields
  localparam int B_WARN_FLAG = 7;
  localparam int B_WARN_ACK = 6;
  localparam int B_UV_TRIP = 5;
  localparam int B_WARN_TRIP = 4;
  // reset and fill values
  localparam logic BIT_CLR = 1'b0;
  localparam logic BIT_SET = 1'b1;
  localparam logic [DATA_W-1:0] BYTE_CLR = 8'h00;
endpackage : pmsc_pkg

/* src/level_sync.sv */
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, not pulses
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = ce ? d : meta_reg;
    sync_next = ce ? meta_reg : sync_reg;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q = sync_reg;
endmodule : level_sync
`default_nettype wire

/* test/power_mgmt_status_control_bench.sv */
// Purpose: self-checking bench for the power management status/control block
// Assumes: undervolt ack writes are made with the comparator level low; one warning ack is written while the warning is still present
// Notes: int model of the three registers is compared at every read and output check
`timescale 1ns/1ps
`default_nettype none
module power_mgmt_status_control_bench;
  logic clk, sys_rst, por_rst, ce, reg_wr, reg_rd;
  logic [pmsc_pkg::ADDR_W-1:0] reg_addr;
  logic [pmsc_pkg::DATA_W-1:0] reg_wdata, reg_rdata;
  logic undervolt_det_raw, supply_warn_raw, stop_active, full_pd_wake, partial_pd_wake;
  logic undervolt_irq, undervolt_rst, undervolt_det_run, ref_buffer_en;
  logic undervolt_trip_sel, supply_warn_trip_sel, powerdown_allow, powerdown_kind_sel, io_hold;
  int m[4];
  bit locked;
  int n_fail, comparisons;
  logic [7:0] ctl;

  power_mgmt_status_control power_mgmt_status_control_i (
    .clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .undervolt_det_raw(undervolt_det_raw),
    .supply_warn_raw(supply_warn_raw), .stop_active(stop_active),
    .full_pd_wake(full_pd_wake), .partial_pd_wake(partial_pd_wake),
    .undervolt_irq(undervolt_irq), .undervolt_rst(undervolt_rst),
    .undervolt_det_run(undervolt_det_run), .ref_buffer_en(ref_buffer_en),
    .undervolt_trip_sel(undervolt_trip_sel), .supply_warn_trip_sel(supply_warn_trip_sel),
    .powerdown_allow(powerdown_allow), .powerdown_kind_sel(powerdown_kind_sel),
    .io_hold(io_hold)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    case (a)
      2'h0: m[0] = (d[6] ? 0 : m[0] & 8'h80) | (d & 8'h3d);
      2'h1: begin
        if (!locked) m[1] = (m[1] & 8'h18) | (d & 8'h03);
        locked = 1'b1;
        if (d[2]) m[1] = m[1] & 8'hf7;
      end
      2'h2: m[2] = ((d[6] && !supply_warn_raw) ? 0 : m[2] & 8'h80) | (d & 8'h30);
      default: ;
    endcase
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, 8'(m[a]));
    @(posedge clk);
    #1 chk("rdata idle", reg_rdata, 8'h00);
  endtask : rd

  task automatic outs();
    repeat (2) @(posedge clk);
    #1 chk("irq", 8'(undervolt_irq), 8'(m[0][7] & m[0][5] & m[0][2]));
    chk("rst req", 8'(undervolt_rst), 8'(m[0][7] & m[0][4] & m[0][2]));
    chk("run", 8'(undervolt_det_run), 8'(m[0][2] & (!stop_active | m[0][3])));
    chk("ref buf", 8'(ref_buffer_en), 8'(m[0][0]));
    chk("trips", 8'({undervolt_trip_sel, supply_warn_trip_sel}), 8'(m[2][5:4]));
    chk("pd", 8'({powerdown_allow, powerdown_kind_sel}), 8'(m[1][1:0]));
    chk("io hold", 8'(io_hold), 8'(m[1][3]));
  endtask : outs

  task automatic do_reset(input bit por);
    @(posedge clk);
    sys_rst <= 1'b1;
    por_rst <= por;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    m[0] = 0;
    m[1] = por ? 0 : m[1] & 8'h18;
    m[2] = por ? 0 : m[2] & 8'h30;
    locked = 1'b0;
  endtask : do_reset

  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    conclude();
  end

  initial begin
    {sys_rst, por_rst, reg_wr, reg_rd, undervolt_det_raw, supply_warn_raw} <= 6'h00;
    {stop_active, full_pd_wake, partial_pd_wake} <= 3'h0;
    ce <= 1'b1;
    reg_addr <= 2'h0;
    reg_wdata <= 8'h00;
    m = '{0, 0, 0, 0};
    void'($urandom(83));
    do_reset(1'b1);
    for (int a = 0; a < 4; a++) rd(2'(a));
    // random controls; reserved bit kept 0 as software must
    for (int i = 0; i < 6; i++) begin
      ctl = (i == 0) ? 8'h35 : 8'($urandom) & 8'h3d;
      wr(2'h0, ctl);
      @(posedge clk);
      stop_active <= (i == 0) ? 1'b0 : 1'($urandom);
      undervolt_det_raw <= 1'b1;
      repeat (6) @(posedge clk);
      if (ctl[2] && (!stop_active || ctl[3])) m[0] = m[0] | 8'h80;
      rd(2'h0);
      outs();
      // detector must be quiet before stop ends, else a late set slips in
      @(posedge clk);
      undervolt_det_raw <= 1'b0;
      repeat (4) @(posedge clk);
      stop_active <= 1'b0;
      wr(2'h0, ctl | 8'h40);
      rd(2'h0);
      outs();
    end
    // strobes while frozen must be ignored
    @(posedge clk);
    ce <= 1'b0;
    reg_wdata <= 8'h3d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    ce <= 1'b1;
    rd(2'h0);
    wr(2'h2, 8'($urandom) & 8'h30);
    @(posedge clk);
    supply_warn_raw <= 1'b1;
    repeat (5) @(posedge clk);
    m[2] = m[2] | 8'h80;
    rd(2'h2);
    wr(2'h2, 8'(m[2] & 8'h30) | 8'h40);
    rd(2'h2);
    supply_warn_raw <= 1'b0;
    repeat (4) @(posedge clk);
    wr(2'h2, 8'(m[2] & 8'h30) | 8'h40);
    rd(2'h2);
    outs();
    wr(2'h1, 8'h03);
    wr(2'h1, 8'h00);
    rd(2'h1);
    outs();
    @(posedge clk);
    full_pd_wake <= 1'b1;
    @(posedge clk);
    full_pd_wake <= 1'b0;
    partial_pd_wake <= 1'b1;
    @(posedge clk);
    partial_pd_wake <= 1'b0;
    m[1] = m[1] | 8'h18;
    rd(2'h1);
    outs();
    wr(2'h1, 8'h04);
    rd(2'h1);
    @(posedge clk);
    partial_pd_wake <= 1'b1;
    @(posedge clk);
    partial_pd_wake <= 1'b0;
    m[1] = m[1] | 8'h08;
    wr(2'h1, 8'h00);
    rd(2'h1);
    do_reset(1'b0);
    for (int a = 0; a < 3; a++) rd(2'(a));
    outs();
    wr(2'h1, 8'h02);
    rd(2'h1);
    @(posedge clk);
    supply_warn_raw <= 1'b1;
    do_reset(1'b1);
    repeat (4) @(posedge clk);
    m[2] = m[2] | 8'h80;
    for (int a = 0; a < 3; a++) rd(2'(a));
    wr(2'h3, 8'hff);
    rd(2'h3);
    outs();
    conclude();
  end
endmodule : power_mgmt_status_control_bench
`default_nettype wire
